/* hub_address_decoder.v */
/*
 Address decoder of the platform hub: steers upstream I/O and memory
 cycles to one internal target and applies boot-block swapping.
 Assumes one cycle presented per clock with a valid strobe, and
 configuration bits held steady by software while cycles run.
*/
// What this block does
// - No overlap checks against fixed I/O
// - Legacy 8-byte port windows go to eSPI
// - Storage index/data 16-byte window to SATA
// - Unclaimed upstream memory cycle is aborted
// - Root-port memory decoded outside bridge windows
// - E and F segments gated by bits 6,7
// - Bits 8-14 gate 512KB flash window pairs
// - Bits 0-3 gate 1MB flash window pairs
// - Top flash windows always decode to flash
// - Interrupt router window placed and enabled
// - Per-port 32KB interrupt windows when enabled
// - Patch region to flash when enabled
// - Event timer in one of four slots
// - Trusted window to flash or engine by strap
// - Fabric error range always decoded
// - FED60000-FED61FFF never positively decoded
// - Generic 64KB memory windows, bit0 enable
// - Swap strap inverts flash lines per block size
// - Swap off passes flash address unchanged
// - Block sizes 64KB-1MB; others reserved
`timescale 1ns/1ps
`include "hub_decoder_map.vh"
module hub_address_decoder (
  input wire core_clk,
  input wire rst_n,
  input wire cyc_valid,
  input wire cyc_is_io,
  input wire cyc_from_root_port,
  input wire [31:0] cyc_addr,
  input wire cfg_wr,
  input wire [11:0] cfg_addr,
  input wire [31:0] cfg_wdata,
  input wire cfg_rd,
  output reg [31:0] cfg_rdata,
  input wire [14:0] flash_decode_enable,
  input wire [7:0] irq_router_range_select,
  input wire irq_router_window_enable,
  input wire [6:0] port_irq_window_enable,
  input wire patch_region_enable,
  input wire [1:0] event_timer_slot,
  input wire trust_to_security_engine,
  input wire boot_swap_strap,
  input wire [2:0] swap_block_size,
  input wire [1:0] par_port_sel,
  input wire par_port_en,
  input wire [2:0] ser1_sel,
  input wire ser1_en,
  input wire [2:0] ser2_sel,
  input wire ser2_en,
  input wire ser3_sel,
  input wire ser3_en,
  input wire [15:0] io_par_bases,
  input wire [127:0] io_ser_bases,
  input wire [31:0] io_ser3_bases,
  input wire [111:0] gen_io_base,
  input wire [55:0] gen_io_mask,
  input wire [6:0] gen_io_en,
  input wire [15:0] sata_io_base,
  input wire sata_io_en,
  input wire [15:0] bridge_mem_base,
  input wire [15:0] bridge_mem_limit,
  input wire bridge_mem_en,
  output reg out_valid,
  output reg [3:0] out_target,
  output reg [31:0] out_addr
);

  reg [31:0] gmem [0:3];
  reg [3:0] next_target;
  reg [31:0] next_addr;
  reg [31:0] swap_mask;
  wire [15:0] io_a = cyc_addr[15:0];
  wire [6:0] gen_hit;
  wire [3:0] gmem_hit;

  function [2:0] gmem_index;
    input [11:0] a;
    begin
      case (a)
        `OFS_GMEM_CS0: gmem_index = 3'b100;
        `OFS_GMEM_CS1: gmem_index = 3'b101;
        `OFS_GMEM_CS2: gmem_index = 3'b110;
        `OFS_GMEM_CS3: gmem_index = 3'b111;
        default: gmem_index = 3'b000;
      endcase
    end
  endfunction

  function io8_hit;
    input [15:0] a;
    input [15:0] b;
    begin
      io8_hit = (a[15:`IO_PAR_SIZE_LOG] == b[15:`IO_PAR_SIZE_LOG]);
    end
  endfunction

  wire [2:0] gdec = gmem_index(cfg_addr);

  // Generic memory window registers
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gmem[0] <= `GMEM_RESET;
      gmem[1] <= `GMEM_RESET;
      gmem[2] <= `GMEM_RESET;
      gmem[3] <= `GMEM_RESET;
    end
    else if (cfg_wr && gdec[2])
      gmem[gdec[1:0]] <= cfg_wdata;
  end

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_rdata <= 32'h00000000;
    else if (cfg_rd)
      cfg_rdata <= gdec[2] ? gmem[gdec[1:0]] : 32'h00000000;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : g_io
      // Mask bits set mark address bits ignored (size 4-256)
      assign gen_hit[gi] = gen_io_en[gi] &&
        (((io_a ^ gen_io_base[gi*16 +: 16]) &
          ~{8'h00, gen_io_mask[gi*8 +: 8] | 8'h03}) == 16'h0000);
    end
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_mem
      assign gmem_hit[gi] = gmem[gi][`GMEM_EN_BIT] &&
        (cyc_addr[31:16] ==
         gmem[gi][`GMEM_BASE_HI:`GMEM_BASE_LO]);
    end
  endgenerate

  // Boot-block swap mask
  always @*
  begin
    swap_mask = 32'h00000000;
    if (boot_swap_strap)
    begin
      case (swap_block_size)
        3'b000: swap_mask = 32'h00010000;
        3'b001: swap_mask = 32'h00020000;
        3'b010: swap_mask = 32'h00040000;
        3'b011: swap_mask = 32'h00080000;
        3'b100: swap_mask = 32'h00100000;
        default: swap_mask = 32'h00000000;
      endcase
    end
  end

  // Swap region is the top two blocks only
  wire in_swap = ((cyc_addr | ({swap_mask[30:0], 1'b0} - 32'h1)) ==
    32'hffffffff) && (swap_mask != 32'h0);

  // Decode with priority; one outcome per cycle
  always @*
  begin
    next_target = `TGT_NONE;
    next_addr = cyc_addr;
    if (cyc_is_io)
    begin
      // Overlap with fixed ranges is not checked
      if (par_port_en && io8_hit(io_a,
          {io_par_bases[par_port_sel*4 +: 4], 12'h000} |
          {4'h0, io_par_bases[par_port_sel*4 +: 4], 8'h00}))
        next_target = `TGT_ESPI_LEGACY;
      else if ((ser1_en && io8_hit(io_a, io_ser_bases[ser1_sel*16 +: 16]))
        || (ser2_en && io8_hit(io_a,
            io_ser_bases[ser2_sel*16 +: 16] ^ 16'h0100))
        || (ser3_en && io8_hit(io_a, io_ser3_bases[ser3_sel*16 +: 16])))
        next_target = `TGT_ESPI_LEGACY;
      else if (|gen_hit[3:0])
        next_target = `TGT_ESPI_CS0;
      else if (gen_hit[4])
        next_target = `TGT_ESPI_CS1;
      else if (gen_hit[5])
        next_target = `TGT_ESPI_CS2;
      else if (gen_hit[6])
        next_target = `TGT_ESPI_CS3;
      else if (sata_io_en && io_a[15:`IO_SATA_SIZE_LOG] ==
               sata_io_base[15:`IO_SATA_SIZE_LOG])
        next_target = `TGT_SATA;
    end
    else if (cyc_from_root_port)
    begin
      // Peer traffic inside bridge window is left alone
      if (!(bridge_mem_en && cyc_addr[31:16] >= bridge_mem_base &&
            cyc_addr[31:16] <= bridge_mem_limit))
        next_target = `TGT_ROOT_PORT;
    end
    else
    begin
      next_target = `TGT_ABORT;
      if (cyc_addr[31:13] == `NODEC_BASE)
        next_target = `TGT_ABORT;
      else if (cyc_addr[31:16] == `SEG_E_BASE)
      begin
        if (flash_decode_enable[`FLASH_EN_E_SEG])
          next_target = `TGT_FLASH;
      end
      else if (cyc_addr[31:16] == `SEG_F_BASE)
      begin
        if (flash_decode_enable[`FLASH_EN_F_SEG])
          next_target = `TGT_FLASH;
      end
      else if (cyc_addr[31:19] == `FLASH_TOP_BASE ||
               cyc_addr[31:19] == `FLASH_TOP_ALIAS)
      begin
        next_target = `TGT_FLASH;
        next_addr = cyc_addr ^ (in_swap ? swap_mask : 32'h0);
      end
      else if (cyc_addr[31:23] == 9'h1ff &&
               cyc_addr[22:19] != 4'hf &&
               flash_decode_enable[`FLASH_EN_512_LO +
                 {29'h0, cyc_addr[21:19]}])
        next_target = `TGT_FLASH;
      else if (cyc_addr[31:23] == 9'h1fe &&
               flash_decode_enable[`FLASH_EN_1M_LO +
                 {30'h0, cyc_addr[21:20]}])
        next_target = `TGT_FLASH;
      else if (cyc_addr[31:20] == `PATCH_BASE)
      begin
        if (patch_region_enable)
          next_target = `TGT_FLASH;
      end
      else if (cyc_addr[31:20] == `IRQ_RTR_PAGE &&
               cyc_addr[19:12] == irq_router_range_select &&
               cyc_addr[11:0] <= {4'h0, `IRQ_RTR_LAST} &&
               irq_router_window_enable)
        next_target = `TGT_IRQ_RTR;
      else if (cyc_addr[31:20] == `IRQ_RTR_PAGE &&
               cyc_addr[19:15] >= 5'h02 && cyc_addr[19:15] <= 5'h08 &&
               port_irq_window_enable[cyc_addr[17:15] - 3'h2])
        next_target = `TGT_ROOT_PORT;
      else if (cyc_addr[31:12] == `TIMER_BASE + {18'h0, event_timer_slot}
               && cyc_addr[11:10] == 2'b00)
        next_target = `TGT_TIMER;
      else if (cyc_addr[31:15] == `TRUST_BASE)
        next_target = trust_to_security_engine ?
          `TGT_SEC_ENG : `TGT_FLASH;
      else if (cyc_addr[31:14] == `FAB_ERR_BASE)
        next_target = `TGT_FAB_ERR;
      else if (gmem_hit[0])
        next_target = `TGT_ESPI_CS0;
      else if (gmem_hit[1])
        next_target = `TGT_ESPI_CS1;
      else if (gmem_hit[2])
        next_target = `TGT_ESPI_CS2;
      else if (gmem_hit[3])
        next_target = `TGT_ESPI_CS3;
    end
  end

  // Registered single outcome
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_valid <= 1'b0;
      out_target <= `TGT_NONE;
      out_addr <= 32'h00000000;
    end
    else
    begin
      out_valid <= cyc_valid;
      out_target <= cyc_valid ? next_target : `TGT_NONE;
      out_addr <= next_addr;
    end
  end

endmodule

/* hub_address_decoder_test.sv */
/*
 Self-checking bench for the hub address decoder.
 Assumes the upstream model drives cycles; all else driven here.
*/
`timescale 1ns/1ps
`include "hub_decoder_map.vh"
module hub_address_decoder_test;
  reg core_clk, rst_n, cfg_wr, cfg_rd, irq_router_window_enable;
  reg patch_region_enable, trust_to_security_engine, boot_swap_strap;
  reg par_port_en, ser1_en, ser2_en, ser3_en, ser3_sel, sata_io_en;
  reg bridge_mem_en;
  reg [1:0] par_port_sel, event_timer_slot;
  reg [2:0] ser1_sel, ser2_sel, swap_block_size;
  reg [6:0] port_irq_window_enable, gen_io_en;
  reg [7:0] irq_router_range_select;
  reg [11:0] cfg_addr;
  reg [14:0] flash_decode_enable;
  reg [15:0] io_par_bases, sata_io_base, bridge_mem_base, bridge_mem_limit;
  reg [31:0] cfg_wdata, io_ser3_bases, seed;
  reg [55:0] gen_io_mask;
  reg [111:0] gen_io_base;
  reg [127:0] io_ser_bases;
  wire cyc_valid, cyc_is_io, cyc_from_root_port, out_valid;
  wire [3:0] out_target;
  wire [31:0] cyc_addr, cfg_rdata, out_addr;
  integer err_total, cmp_count, cycles, i;
  hub_address_decoder hub_address_decoder_inst (.*);
  upstream_die_model upstream (.*);
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [11:0] ofs(input [1:0] n);
    ofs = n[1] ? (n[0] ? `OFS_GMEM_CS3 : `OFS_GMEM_CS2)
      : (n[0] ? `OFS_GMEM_CS1 : `OFS_GMEM_CS0);
  endfunction
  function [3:0] exp_flash(input [31:0] a);
    exp_flash = (a[23] ? (&a[21:19] | flash_decode_enable[4'd8 + a[21:19]])
      : flash_decode_enable[a[21:20]]) ? `TGT_FLASH : `TGT_ABORT;
  endfunction
  task conclude;
  begin
    if (err_total == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  end
  endtask
  task run(input io, input [31:0] a, input [3:0] t, input [31:0] oa);
  begin
    upstream.issue(io, 1'b0, a);
    check({31'h0, out_valid}, 32'h1);
    check({28'h0, out_target}, {28'h0, t});
    if (!io)
      check(out_addr, oa);
  end
  endtask
  task cfg_io(input wr, input [11:0] a, input [31:0] d);
  begin
    cfg_wr = wr;
    cfg_rd = !wr;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge core_clk);
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    if (!wr)
      check(cfg_rdata, d);
  end
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      err_total = err_total + 1;
      conclude;
    end
  end
  initial
  begin
    {rst_n, cfg_wr, cfg_rd, irq_router_window_enable, patch_region_enable,
      trust_to_security_engine, boot_swap_strap, par_port_en, ser1_en,
      ser2_en, ser3_en, ser3_sel, sata_io_en, bridge_mem_en, par_port_sel,
      event_timer_slot, ser1_sel, ser2_sel, swap_block_size,
      port_irq_window_enable, gen_io_en, irq_router_range_select, cfg_addr,
      flash_decode_enable, io_par_bases, sata_io_base, bridge_mem_base,
      bridge_mem_limit, cfg_wdata, io_ser3_bases, gen_io_mask, gen_io_base,
      io_ser_bases} = '0;
    {err_total, cmp_count, cycles} = '0;
    seed = 32'd99742;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
      cfg_io(1'b0, ofs(i[1:0]), `GMEM_RESET);
      cfg_io(1'b1, ofs(i[1:0]), {16'h1230 + i[15:0], 16'h0001});
      cfg_io(1'b0, ofs(i[1:0]), {16'h1230 + i[15:0], 16'h0001});
      run(0, {16'h1230 + i[15:0], 16'hfffc}, `TGT_ESPI_CS0 + i[3:0],
        {16'h1230 + i[15:0], 16'hfffc});
    end
    cfg_io(1'b1, 12'h0ac, 32'hffffffff);
    cfg_io(1'b0, 12'h0ac, 32'h0);
    cfg_io(1'b1, ofs(0), 32'h12300000);
    run(0, 32'h12300000, `TGT_ABORT, 32'h12300000);
    run(0, 32'h000e1234, `TGT_ABORT, 32'h000e1234);
    run(0, 32'hfef00010, `TGT_ABORT, 32'hfef00010);
    flash_decode_enable = 15'h00c0;
    patch_region_enable = 1'b1;
    run(0, 32'h000efff0, `TGT_FLASH, 32'h000efff0);
    run(0, 32'h000f0000, `TGT_FLASH, 32'h000f0000);
    run(0, 32'hfeffffff, `TGT_FLASH, 32'hfeffffff);
    run(0, 32'hfed4fffc, `TGT_FAB_ERR, 32'hfed4fffc);
    run(0, 32'hfed61ffc, `TGT_ABORT, 32'hfed61ffc);
    for (i = 0; i < 4; i = i + 1)
    begin
      event_timer_slot = i[1:0];
      trust_to_security_engine = i[0];
      run(0, {16'hfed0, i[3:0], 12'h3fc}, `TGT_TIMER, {16'hfed0, i[3:0],
        12'h3fc});
      run(0, 32'hfed40000, i[0] ? `TGT_SEC_ENG : `TGT_FLASH,
        32'hfed40000);
    end
    run(0, 32'hffff0010, `TGT_FLASH, 32'hffff0010);
    boot_swap_strap = 1'b1;
    for (i = 0; i < 5; i = i + 1)
    begin
      swap_block_size = i[2:0];
      run(0, 32'hffff0010, `TGT_FLASH, 32'hffff0010 ^ (32'h10000 << i));
    end
    swap_block_size = 3'h0;
    run(0, 32'hfff80004, `TGT_FLASH, 32'hfff80004);
    boot_swap_strap = 1'b0;
    sata_io_en = 1'b1;
    sata_io_base = 16'h5670;
    gen_io_en = 7'h10;
    gen_io_base[79:64] = 16'h2a00;
    ser3_en = 1'b1;
    io_ser3_bases = {16'h03e8, 16'h03e8};
    run(1, 32'h0000567c, `TGT_SATA, 0);
    run(1, 32'h00005680, `TGT_NONE, 0);
    run(1, 32'h00002a03, `TGT_ESPI_CS1, 0);
    run(1, 32'h00002a04, `TGT_NONE, 0);
    run(1, 32'h000003ef, `TGT_ESPI_LEGACY, 0);
    run(1, 32'h000003f0, `TGT_NONE, 0);
    bridge_mem_en = 1'b1;
    bridge_mem_base = 16'h8000;
    bridge_mem_limit = 16'h8fff;
    upstream.issue(1'b0, 1'b1, 32'h80001000);
    check({28'h0, out_target}, {28'h0, `TGT_NONE});
    upstream.issue(1'b0, 1'b1, 32'h90000000);
    check({28'h0, out_target}, {28'h0, `TGT_ROOT_PORT});
    irq_router_window_enable = 1'b1;
    port_irq_window_enable = 7'h10;
    run(0, 32'hfec00040, `TGT_IRQ_RTR, 32'hfec00040);
    run(0, 32'hfec00044, `TGT_ABORT, 32'hfec00044);
    run(0, 32'hfec30000, `TGT_ROOT_PORT, 32'hfec30000);
    run(0, 32'hfec28000, `TGT_ABORT, 32'hfec28000);
    upstream.idle;
    @(negedge core_clk);
    for (i = 0; i < 200; i = i + 1)
    begin
      seed = lfsr(seed);
      flash_decode_enable = seed[14:0];
      seed = lfsr(seed);
      run(0, {8'hff, seed[23:0]}, exp_flash({8'hff, seed[23:0]}),
        {8'hff, seed[23:0]});
    end
    upstream.idle;
    conclude;
  end
endmodule

/* hub_decoder_map.vh */
/*
 Constants for the hub address decoder: register offsets, field
 positions, reset values and fixed window bases.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef HUB_DECODER_MAP_VH
`define HUB_DECODER_MAP_VH

`define OFS_GMEM_CS0 12'h098
`define OFS_GMEM_CS1 12'h0a8
`define OFS_GMEM_CS2 12'h208
`define OFS_GMEM_CS3 12'h248
`define GMEM_EN_BIT 0
`define GMEM_BASE_HI 31
`define GMEM_BASE_LO 16
`define GMEM_RESET 32'h00000000

`define FLASH_EN_E_SEG 6
`define FLASH_EN_F_SEG 7
`define FLASH_EN_512_LO 8
`define FLASH_EN_1M_LO 0

`define SEG_E_BASE 16'h000e
`define SEG_F_BASE 16'h000f
`define FLASH_512_BASE 13'h1ff8
`define FLASH_1M_BASE 12'hff4
`define FLASH_TOP_BASE 13'h1fff
`define FLASH_TOP_ALIAS 13'h1ff7
`define IRQ_RTR_PAGE 12'hfec
`define IRQ_RTR_LAST 8'h40
`define PORT_IRQ_BASE 17'h1fd82
`define PATCH_BASE 12'hfef
`define TIMER_BASE 20'hfed00
`define TRUST_BASE 17'h1fda8
`define FAB_ERR_BASE 18'h3fb53
`define NODEC_BASE 19'h7f6b0

`define IO_PAR_SIZE_LOG 3
`define IO_SATA_SIZE_LOG 4

`define TGT_NONE 4'h0
`define TGT_ABORT 4'h1
`define TGT_FLASH 4'h2
`define TGT_ESPI_CS0 4'h3
`define TGT_ESPI_CS1 4'h4
`define TGT_ESPI_CS2 4'h5
`define TGT_ESPI_CS3 4'h6
`define TGT_SATA 4'h7
`define TGT_IRQ_RTR 4'h8
`define TGT_ROOT_PORT 4'h9
`define TGT_TIMER 4'ha
`define TGT_SEC_ENG 4'hb
`define TGT_FAB_ERR 4'hc
`define TGT_ESPI_LEGACY 4'hd

`endif

/* hub_decoder_sva.sv */
/*
 Concurrent checks on the hub address decoder ports.
 Assumes binding to hub_address_decoder and one core_clk domain.
*/
`timescale 1ns/1ps
`include "hub_decoder_map.vh"
module hub_decoder_sva (
  input wire core_clk,
  input wire rst_n,
  input wire cyc_valid,
  input wire cyc_is_io,
  input wire cyc_from_root_port,
  input wire [31:0] cyc_addr,
  input wire [14:0] flash_decode_enable,
  input wire patch_region_enable,
  input wire [1:0] event_timer_slot,
  input wire trust_to_security_engine,
  input wire boot_swap_strap,
  input wire [2:0] swap_block_size,
  input wire out_valid,
  input wire [3:0] out_target,
  input wire [31:0] out_addr
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Upstream memory cycle taken
  sequence up_mem;
    cyc_valid && !cyc_is_io && !cyc_from_root_port;
  endsequence
  // Top block request with swapping off
  sequence top_plain;
    up_mem ##0 (cyc_addr[31:19] == `FLASH_TOP_BASE && !boot_swap_strap);
  endsequence
  chk_valid_follow: assert property (cyc_valid |=> out_valid)
    else $error("no answer after a cycle");
  chk_idle_quiet: assert property (!cyc_valid |=> !out_valid)
    else $error("answer without a cycle");
  chk_top_flash: assert property (top_plain |=>
    out_target == `TGT_FLASH && out_addr == $past(cyc_addr))
    else $error("top block not passed to flash");
  chk_swap_small: assert property (up_mem ##0 (cyc_addr[31:16] ==
    16'hffff && boot_swap_strap && swap_block_size == 3'h0) |=>
    out_addr == ($past(cyc_addr) ^ 32'h00010000))
    else $error("64KB swap wrong");
  chk_seg_e: assert property (up_mem ##0 cyc_addr[31:16] == 16'h000e
    |=> out_target == ($past(flash_decode_enable[6]) ?
    `TGT_FLASH : `TGT_ABORT))
    else $error("E segment decode wrong");
  chk_patch_gate: assert property (up_mem ##0 cyc_addr[31:20] ==
    `PATCH_BASE |=> out_target == ($past(patch_region_enable) ?
    `TGT_FLASH : `TGT_ABORT))
    else $error("patch region decode wrong");
  chk_fab_err: assert property (up_mem ##0 cyc_addr[31:14] ==
    `FAB_ERR_BASE |=> out_target == `TGT_FAB_ERR)
    else $error("fabric error range missed");
  chk_no_decode: assert property (up_mem ##0 cyc_addr[31:13] ==
    `NODEC_BASE |=> out_target == `TGT_ABORT)
    else $error("reserved range claimed");
  chk_trust_route: assert property (up_mem ##0 cyc_addr[31:15] ==
    `TRUST_BASE |=> out_target == ($past(trust_to_security_engine) ?
    `TGT_SEC_ENG : `TGT_FLASH))
    else $error("trusted window routed wrong");
  chk_timer_slot: assert property (up_mem ##0 (cyc_addr[31:16] ==
    16'hfed0 && cyc_addr[15:10] == {2'b00, event_timer_slot, 2'b00})
    |=> out_target == `TGT_TIMER)
    else $error("timer slot missed");
endmodule
bind hub_address_decoder hub_decoder_sva hub_decoder_sva_inst (.*);

/* upstream_die_model.sv */
/*
 Compute die side: issues I/O and memory cycles to the decoder.
 Assumes its tasks are entered just after a falling edge.
*/
`timescale 1ns/1ps
module upstream_die_model (
  input wire core_clk,
  output reg cyc_valid,
  output reg cyc_is_io,
  output reg cyc_from_root_port,
  output reg [31:0] cyc_addr
);
  initial
  begin
    cyc_valid = 1'b0;
    cyc_is_io = 1'b0;
    cyc_from_root_port = 1'b0;
    cyc_addr = 32'h00000000;
  end
  // One cycle, left asserted until the next issue or idle; no locked accesses
  // I/O targets kept off fixed ranges
  task issue(input io, input rp, input [31:0] a);
  begin
    cyc_valid = 1'b1;
    cyc_is_io = io;
    cyc_from_root_port = rp;
    cyc_addr = a;
    @(negedge core_clk);
  end
  endtask
  // Released address shows the inverse of the last value
  task idle;
  begin
    cyc_valid = 1'b0;
    cyc_addr = ~cyc_addr;
  end
  endtask
endmodule
